/* File: verilog/brgc_pkg.sv */
/*
  Package of the bus-reset and gap-count control block: field widths,
  values after reset and the count of back-to-back bus resets that forces
  the gap count to its maximum.
  Assumes nothing of its surroundings; it is imported by every module.
*/
package brgc_pkg;

  // ---------------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------------
  localparam int unsigned GAP_W = 6;
  localparam int unsigned CNT_W = 2;

  // ---------------------------------------------------------------------
  // Values
  // ---------------------------------------------------------------------
  // Largest gap count, also used after repeated bus resets.
  localparam logic [GAP_W-1:0] GAP_MAX = 6'h3F;
  // Value after system reset of the gap-count field.
  localparam logic [GAP_W-1:0] GAP_RST = 6'h3F;
  // Value after system reset of the root-holdoff bit.
  localparam logic RHB_RST = 1'b0;
  // Bus resets in a row, with no load in between, that force GAP_MAX.
  localparam logic [CNT_W-1:0] RESETS_TO_MAX = 2'h2;
  // Value after system reset of the consecutive-reset counter.
  localparam logic [CNT_W-1:0] CNT_RST = 2'h0;

endpackage : brgc_pkg

/* File: verilog/brgc_reset_counter.sv */
/*
  Counter of consecutive bus resets that saw no gap-count load between
  them. It tells the main block when the next bus reset must force the
  gap count to its maximum.
  Assumes load_i and bus_reset_i come from logic on core_clk_i.
*/
`timescale 1ns/100ps

module brgc_reset_counter
  import brgc_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // Events
  input  wire logic load_i,
  input  wire logic bus_reset_i,
  // Decision
  output logic      force_max_o
);

  logic [CNT_W-1:0] cnt_q;

  // ---------------------------------------------------------------------
  // Counting
  // ---------------------------------------------------------------------
  // clear and count
  // A load in the same cycle as a reset counts as coming first, so that
  // reset is the first of a new run; the counter saturates.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_q <= CNT_RST;
    end else if (load_i) begin
      cnt_q <= bus_reset_i ? 2'h1 : CNT_RST;
    end else if (bus_reset_i && (cnt_q != RESETS_TO_MAX)) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  assign force_max_o = bus_reset_i && !load_i && (cnt_q >= (RESETS_TO_MAX - 2'h1));

  property p_cnt_clear;
    @(posedge core_clk_i) disable iff (rst_i)
    (load_i && !bus_reset_i) |=> (cnt_q == CNT_RST);
  endproperty
  a_cnt_clear: assert property (p_cnt_clear)
    else $error("reset counter not cleared by a load");

endmodule // brgc_reset_counter

/* File: verilog/brgc_top.sv */
/*
  Bus-reset and arbitration-gap control of a serial-bus physical layer.
  It turns the bus-reset trigger into a reset request and holds the root-holdoff
  bit and gap-count field of physical-layer register 1, loads them from register writes and from
  sent or received configuration packets, and forces the gap count to its
  maximum after repeated bus resets.
  Assumes every input is a one-cycle pulse or level from logic on
  core_clk_i, so no synchroniser is needed.
*/
`timescale 1ns/100ps

module brgc_top
  import brgc_pkg::*;
(
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  // Register 1 write from the link
  input  wire logic             reg1_wr_i,
  input  wire logic             reg1_start_bus_reset_bit_i,
  input  wire logic             reg1_root_holdoff_bit_i,
  input  wire logic [GAP_W-1:0] reg1_gap_count_i,
  // Configuration packet seen on the bus
  input  wire logic             cfg_pkt_rx_i,
  input  wire logic             cfg_pkt_tx_i,
  input  wire logic             cfg_pkt_root_holdoff_bit_i,
  input  wire logic [GAP_W-1:0] cfg_pkt_gap_count_i,
  // Bus reset occurrence from the arbitration logic
  input  wire logic             bus_reset_done_i,
  // Bus reset request
  output logic                  bus_reset_req_o,
  output logic                  bus_reset_pending_o,
  // Register 1 read image
  output logic                  root_holdoff_bit_o,
  output logic [GAP_W-1:0]      gap_count_o
);

  // ---------------------------------------------------------------------
  // Load decode
  // ---------------------------------------------------------------------
  logic             wr_load;
  logic             pkt_load;
  logic             any_load;
  logic             force_max;
  logic             rhb_d;
  logic [GAP_W-1:0] gap_d;

  // Any write to register 1 loads both fields; only the trigger bit
  // decides whether a reset starts. A write without the trigger would
  // leave peers inconsistent, which is the link's care, not ours.
  assign wr_load  = reg1_wr_i;
  assign pkt_load = cfg_pkt_rx_i || cfg_pkt_tx_i;
  assign any_load = wr_load || pkt_load;

  // ---------------------------------------------------------------------
  // Consecutive reset tracking
  // ---------------------------------------------------------------------
  brgc_reset_counter u_reset_counter (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .load_i      (any_load),
    .bus_reset_i (bus_reset_done_i),
    .force_max_o (force_max)
  );

  // ---------------------------------------------------------------------
  // Field next values
  // ---------------------------------------------------------------------
  // A register write wins over a packet in the same cycle, as software
  // acts on purpose; a load always wins over a forced maximum.
  always_comb begin
    rhb_d = root_holdoff_bit_o;
    gap_d = gap_count_o;
    if (wr_load) begin
      rhb_d = reg1_root_holdoff_bit_i;
      gap_d = reg1_gap_count_i;
    end else if (pkt_load) begin
      rhb_d = cfg_pkt_root_holdoff_bit_i;
      gap_d = cfg_pkt_gap_count_i;
    end else if (force_max) begin
      gap_d = GAP_MAX;
    end
  end

  // ---------------------------------------------------------------------
  // Register 1 fields
  // ---------------------------------------------------------------------
  // write survives its reset
  // The reset that a write starts is the first of a new run, so the counter does not force
  // here and the written value stays, unless a bus reset falls in the write's own cycle.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      root_holdoff_bit_o <= RHB_RST;
      gap_count_o        <= GAP_RST;
    end else begin
      root_holdoff_bit_o <= rhb_d;
      gap_count_o        <= gap_d;
    end
  end

  // ---------------------------------------------------------------------
  // Bus reset start
  // ---------------------------------------------------------------------
  // trigger bit starts reset
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bus_reset_req_o <= 1'b0;
    end else begin
      bus_reset_req_o <= reg1_wr_i && reg1_start_bus_reset_bit_i;
    end
  end

  // Pending stays up until the arbitration logic reports the reset; a
  // new request in the same cycle as the report wins so none is lost.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bus_reset_pending_o <= 1'b0;
    end else if (bus_reset_req_o) begin
      bus_reset_pending_o <= 1'b1;
    end else if (bus_reset_done_i) begin
      bus_reset_pending_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  property p_req_after_write;
    @(posedge core_clk_i) disable iff (rst_i)
    (reg1_wr_i && reg1_start_bus_reset_bit_i) |=> bus_reset_req_o ##1 bus_reset_pending_o;
  endproperty
  a_req_after_write: assert property (p_req_after_write)
    else $error("trigger write did not start a bus reset");

  property p_req_cause;
    @(posedge core_clk_i) disable iff (rst_i)
    bus_reset_req_o |-> $past(reg1_wr_i && reg1_start_bus_reset_bit_i);
  endproperty
  a_req_cause: assert property (p_req_cause)
    else $error("bus reset request without a trigger write");

  property p_write_loads;
    @(posedge core_clk_i) disable iff (rst_i)
    reg1_wr_i |=> (gap_count_o == $past(reg1_gap_count_i))
                  && (root_holdoff_bit_o == $past(reg1_root_holdoff_bit_i));
  endproperty
  a_write_loads: assert property (p_write_loads)
    else $error("register write did not load the fields");

  property p_rx_loads;
    @(posedge core_clk_i) disable iff (rst_i)
    (cfg_pkt_rx_i && !reg1_wr_i) |=> (gap_count_o == $past(cfg_pkt_gap_count_i))
                                     && (root_holdoff_bit_o == $past(cfg_pkt_root_holdoff_bit_i));
  endproperty
  a_rx_loads: assert property (p_rx_loads)
    else $error("received packet did not load the fields");

  property p_tx_loads;
    @(posedge core_clk_i) disable iff (rst_i)
    (cfg_pkt_tx_i && !reg1_wr_i) |=> (gap_count_o == $past(cfg_pkt_gap_count_i))
                                     && (root_holdoff_bit_o == $past(cfg_pkt_root_holdoff_bit_i));
  endproperty
  a_tx_loads: assert property (p_tx_loads)
    else $error("sent packet did not load the fields");

  property p_two_resets_max;
    @(posedge core_clk_i) disable iff (rst_i)
    (bus_reset_done_i && !any_load) ##1 (bus_reset_done_i && !any_load)
      |=> (gap_count_o == GAP_MAX);
  endproperty
  a_two_resets_max: assert property (p_two_resets_max)
    else $error("gap count not forced after two bus resets");

  property p_write_kept;
    @(posedge core_clk_i) disable iff (rst_i)
    (reg1_wr_i && reg1_start_bus_reset_bit_i) ##1 (bus_reset_done_i && !any_load)
      |=> (gap_count_o == $past(reg1_gap_count_i, 2));
  endproperty
  a_write_kept: assert property (p_write_kept)
    else $error("bus reset lost the written gap count");

  property p_rhb_stable;
    @(posedge core_clk_i) disable iff (rst_i)
    !any_load |=> $stable(root_holdoff_bit_o);
  endproperty
  a_rhb_stable: assert property (p_rhb_stable)
    else $error("root-holdoff changed without a load");

  property p_single_reset_keeps;
    @(posedge core_clk_i) disable iff (rst_i)
    any_load ##1 (bus_reset_done_i && !any_load) |=> $stable(gap_count_o);
  endproperty
  a_single_reset_keeps: assert property (p_single_reset_keeps)
    else $error("first reset after a load changed the gap count");

  // Pending falls once the reset is seen, unless a new request arrives.
  property p_pend_clear;
    @(posedge core_clk_i) disable iff (rst_i)
    (bus_reset_done_i && !bus_reset_req_o) |=> !bus_reset_pending_o;
  endproperty
  a_pend_clear: assert property (p_pend_clear)
    else $error("pending not cleared by the bus reset");

  c_write_reset: cover property (@(posedge core_clk_i) disable iff (rst_i)
    (reg1_wr_i && reg1_start_bus_reset_bit_i) ##2 bus_reset_done_i);
  c_tx_then_reset: cover property (@(posedge core_clk_i) disable iff (rst_i)
    cfg_pkt_tx_i ##1 bus_reset_done_i);
  c_force_max: cover property (@(posedge core_clk_i) disable iff (rst_i)
    force_max);
  c_write_beats_pkt: cover property (@(posedge core_clk_i) disable iff (rst_i)
    reg1_wr_i && (cfg_pkt_rx_i || cfg_pkt_tx_i));

endmodule // brgc_top

/* File: bench/brgc_link_model.sv */
/*
  Link-side model that writes register 1 of the gap control block.
  Assumes the bench calls one of its tasks at a time, off the clock edge.
*/
`timescale 1ns/100ps

module brgc_link_model
  import brgc_pkg::*;
(
  // Clock
  input  wire logic             core_clk_i,
  // Register 1 read image
  input  wire logic             root_holdoff_bit_i,
  input  wire logic [GAP_W-1:0] gap_count_i,
  // Register 1 write
  output logic                  reg1_wr_o,
  output logic                  reg1_start_bus_reset_bit_o,
  output logic                  reg1_root_holdoff_bit_o,
  output logic [GAP_W-1:0]      reg1_gap_count_o
);
  // Idle values; the fields carry junk so that nothing relies on them.
  initial begin
    reg1_wr_o                  = 1'b0;
    reg1_start_bus_reset_bit_o = 1'b0;
    reg1_root_holdoff_bit_o    = 1'b1;
    reg1_gap_count_o           = 6'h2A;
  end

  task automatic write_reg1(input logic root_holdoff_bit, input logic [GAP_W-1:0] gap);
    @(posedge core_clk_i);
    reg1_wr_o                  <= 1'b1;
    reg1_start_bus_reset_bit_o <= 1'b1;
    reg1_root_holdoff_bit_o    <= root_holdoff_bit;
    reg1_gap_count_o           <= gap;
    @(posedge core_clk_i);
    // Released fields show the inverse, so a stale value is never trusted.
    reg1_wr_o                  <= 1'b0;
    reg1_start_bus_reset_bit_o <= 1'b0;
    reg1_root_holdoff_bit_o    <= ~root_holdoff_bit;
    reg1_gap_count_o           <= ~gap;
  endtask

  task automatic reset_after_cfg();
    write_reg1(root_holdoff_bit_i, gap_count_i);
  endtask

  task automatic plain_reset();
    write_reg1(root_holdoff_bit_i, GAP_MAX);
  endtask
endmodule // brgc_link_model

/* File: bench/brgc_top_tb.sv */
/*
  Self-checking bench of the gap control block with a link model.
  Assumes the design answers one cycle after each taken request.
*/
`timescale 1ns/100ps

module brgc_top_tb;
  import brgc_pkg::*;
  logic             core_clk_i = 1'b0;
  logic             rst_i      = 1'b1;
  logic             rx_q       = 1'b0;
  logic             tx_q       = 1'b0;
  logic             pkt_rhb_q  = 1'b1;
  logic [GAP_W-1:0] pkt_gap_q  = 6'h15;
  logic             done_q     = 1'b0;
  logic             wr, trig, wr_rhb, req, pend, root_holdoff_bit;
  logic [GAP_W-1:0] wr_gap, gap;
  int               bad_count  = 0;
  int               n_checks   = 0;

  always #5 core_clk_i = ~core_clk_i;

  brgc_top i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg1_wr_i(wr),
    .reg1_start_bus_reset_bit_i(trig), .reg1_root_holdoff_bit_i(wr_rhb),
    .reg1_gap_count_i(wr_gap), .cfg_pkt_rx_i(rx_q), .cfg_pkt_tx_i(tx_q),
    .cfg_pkt_root_holdoff_bit_i(pkt_rhb_q), .cfg_pkt_gap_count_i(pkt_gap_q),
    .bus_reset_done_i(done_q), .bus_reset_req_o(req), .bus_reset_pending_o(pend),
    .root_holdoff_bit_o(root_holdoff_bit), .gap_count_o(gap));

  brgc_link_model i_link (.core_clk_i(core_clk_i), .root_holdoff_bit_i(root_holdoff_bit),
    .gap_count_i(gap), .reg1_wr_o(wr), .reg1_start_bus_reset_bit_o(trig),
    .reg1_root_holdoff_bit_o(wr_rhb), .reg1_gap_count_o(wr_gap));

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  task automatic chk(input logic [GAP_W-1:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask

  task automatic settle();
    @(posedge core_clk_i);
    #1;
  endtask

  // One bus reset seen by the arbitration logic.
  task automatic pulse_done();
    @(posedge core_clk_i);
    done_q <= 1'b1;
    @(posedge core_clk_i);
    done_q <= 1'b0;
    #1;
  endtask

  // Configuration packet; fields turn to junk once the pulse ends.
  task automatic send_pkt(input logic is_tx, r, input logic [GAP_W-1:0] g);
    @(posedge core_clk_i);
    tx_q      <= is_tx;
    rx_q      <= ~is_tx;
    pkt_rhb_q <= r;
    pkt_gap_q <= g;
    @(posedge core_clk_i);
    {tx_q, rx_q} <= 2'b00;
    pkt_rhb_q    <= ~r;
    pkt_gap_q    <= ~g;
    #1;
  endtask

  // Request pulse for one cycle, then pending until the reset is seen.
  task automatic chk_req();
    #1;
    chk(req, 1'b1, "no bus reset request");
    settle();
    chk(req, 1'b0, "request longer than one cycle");
    chk(pend, 1'b1, "pending not raised");
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic test_reset();
    repeat (4) @(posedge core_clk_i);
    #1;
    chk(gap, GAP_RST, "gap after reset");
    chk(root_holdoff_bit, RHB_RST, "root holdoff after reset");
    chk({req, pend}, 2'b00, "request during reset");
    @(posedge core_clk_i);
    rst_i <= 1'b0;
    $display("test_reset done");
  endtask

  // Packet load, rewrite reset, then a second reset forces the maximum.
  task automatic test_cfg_then_reset();
    send_pkt(1'b1, 1'b1, 6'h05);
    chk(gap, 6'h05, "tx packet gap");
    chk(root_holdoff_bit, 1'b1, "tx packet root holdoff");
    i_link.reset_after_cfg();
    chk_req();
    pulse_done();
    chk(pend, 1'b0, "pending after reset");
    chk(gap, 6'h05, "gap lost after own reset");
    pulse_done();
    chk(gap, GAP_MAX, "no force after two resets");
    chk(root_holdoff_bit, 1'b1, "root holdoff changed by force");
    $display("test_cfg_then_reset done");
  endtask

  // A write and a packet on the same edge: the write fields win.
  task automatic test_collision();
    send_pkt(1'b0, 1'b0, 6'h0C);
    chk(gap, 6'h0C, "rx packet gap");
    fork
      i_link.reset_after_cfg();
      send_pkt(1'b0, 1'b1, 6'h07);
    join
    chk(gap, 6'h0C, "write did not load gap");
    chk(root_holdoff_bit, 1'b0, "write did not load root holdoff");
    chk(req, 1'b1, "no request on collision");
    pulse_done();
    chk(gap, 6'h0C, "first reset after load forced");
    $display("test_collision done");
  endtask

  // A load between two resets restarts the count.
  task automatic test_count_restart();
    pulse_done();
    chk(gap, GAP_MAX, "second reset did not force");
    send_pkt(1'b1, 1'b1, 6'h21);
    pulse_done();
    chk(gap, 6'h21, "count not cleared by load");
    i_link.plain_reset();
    chk_req();
    chk(gap, GAP_MAX, "plain reset gap");
    chk(root_holdoff_bit, 1'b1, "plain reset root holdoff");
    $display("test_count_restart done");
  endtask

  // A load, a reset in the very next cycle, then a second reset at once.
  task automatic test_back_to_back();
    fork
      send_pkt(1'b0, 1'b0, 6'h1B);
      begin
        repeat (2) @(posedge core_clk_i);
        done_q <= 1'b1;
        settle();
        chk(gap, 6'h1B, "reset next to a load forced");
        @(posedge core_clk_i);
        done_q <= 1'b0;
        #1;
      end
    join
    chk(gap, GAP_MAX, "no force after adjacent resets");
    chk(root_holdoff_bit, 1'b0, "root holdoff changed by force");
    chk(pend, 1'b0, "pending after adjacent resets");
    $display("test_back_to_back done");
  endtask

  // A rewrite reset seen one cycle after its write keeps the written gap.
  task automatic test_write_then_reset();
    send_pkt(1'b1, 1'b1, 6'h0A);
    pulse_done();
    chk(gap, 6'h0A, "first reset after packet forced");
    fork
      i_link.reset_after_cfg();
      begin
        repeat (2) @(posedge core_clk_i);
        done_q <= 1'b1;
        @(posedge core_clk_i);
        done_q <= 1'b0;
        #1;
      end
    join
    chk(gap, 6'h0A, "written gap lost to its reset");
    chk(pend, 1'b1, "request lost next to a reset");
    pulse_done();
    chk(gap, GAP_MAX, "later reset did not force");
    chk(pend, 1'b0, "pending after later reset");
    $display("test_write_then_reset done");
  endtask

  // ---------------------------------------------------------------------
  // Verdict and main sequence
  // ---------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // The tests need about forty cycles; five thousand means a hang.
  initial begin
    #50000;
    bad_count++;
    give_verdict();
  end

  initial begin
    test_reset();
    test_cfg_then_reset();
    test_collision();
    test_count_restart();
    test_back_to_back();
    test_write_then_reset();
    give_verdict();
  end
endmodule // brgc_top_tb
